// ### rtl/sysctl_pkg.sv
// Constants, register map and state encodings of the system-control block.
package sysctl_pkg;

   // ==========================================================================
   // Register offsets (byte addresses on the register bus)
   localparam logic [7:0] CTRL_OFF      = 8'h00;
   localparam logic [7:0] STATUS_OFF    = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFF  = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFF  = 8'h0C;
   localparam logic [7:0] WAKE_LO_OFF   = 8'h10;
   localparam logic [7:0] WAKE_HI_OFF   = 8'h14;
   localparam logic [7:0] WAKE_LVL_OFF  = 8'h18;

   // ==========================================================================
   // Vector mapping codes held in the control register
   localparam logic [1:0] MAP_BOOT      = 2'h0;
   localparam logic [1:0] MAP_SRAM      = 2'h1;
   localparam logic [1:0] MAP_EXT       = 2'h2;
   localparam logic [1:0] MAP_RESERVED  = 2'h3;

   // ==========================================================================
   // Status register bit positions
   localparam int ST_BROWNOUT  = 0;
   localparam int ST_DBG_OFF   = 1;
   localparam int ST_OSC_OK    = 2;
   localparam int ST_WAKING    = 3;

   // Interrupt status and mask bit positions
   localparam int IRQ_W        = 3;
   localparam int IRQ_BROWNOUT = 0;
   localparam int IRQ_WAKE     = 1;
   localparam int IRQ_RESUME   = 2;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

   // ==========================================================================
   // Code security
   localparam logic [11:0] SEC_WORD_ADDR = 12'h1FC;
   localparam logic [31:0] SEC_WORD_KEY  = 32'h8765_4321;

   // ==========================================================================
   // Timing counts in system clock cycles
   localparam int          TIMER_W        = 13;
   localparam logic [12:0] RST_HOLD_CLKS  = 13'h0040;
   localparam logic [12:0] WAKE_IRC_CLKS  = 13'h0004;
   localparam logic [12:0] WAKE_MAIN_CLKS = 13'h1000;

   // ==========================================================================
   // Reset sequencer states
   typedef enum logic [1:0] {
      ST_HOLD  = 2'b00,
      ST_COUNT = 2'b01,
      ST_FLASH = 2'b10,
      ST_RUN   = 2'b11
   } rst_state_e;

endpackage : sysctl_pkg

// ### rtl/sync_2ff.sv
// Two-flip-flop synchroniser for a group of asynchronous levels.
module sync_2ff #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // Levels
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= '0;
         q_o  <= '0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end

endmodule : sync_2ff

// ### rtl/cycle_timer.sv
// Down counter that signals when a loaded number of cycles has elapsed.
module cycle_timer #(
   parameter int W = 13
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // Control
   input  wire logic         start_i,
   input  wire logic [W-1:0] len_i,
   // Status
   output logic              busy_o,
   output logic              done_o
);

   logic [W-1:0] cnt;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= '0;
      end else if (start_i) begin
         cnt <= len_i;
      end else if (cnt != '0) begin
         cnt <= cnt - 1'b1;
      end
   end

   // Done is high in the last counted cycle, len_i cycles after the start.
   assign busy_o = (cnt != '0);
   assign done_o = (cnt == W'(1));

endmodule : cycle_timer

// ### rtl/reset_brownout_system_control.sv
// Reset sequencing, brownout handling, code security, vector mapping and wake-up control.
//
// What this block does
// - Internal reset comes from reset pin, watchdog, power-on reset or brownout reset.
// - Reset holds until pin released, oscillator runs, count elapsed, flash initialised.
// - On release the processor fetches at address 0 with boot block vectors mapped.
// - All registers hold their reset values when internal reset is released.
// - First brownout comparator below 2.95 V raises a brownout interrupt request.
// - The request reaches the processor only if enabled; status register shows it too.
// - Second brownout comparator below 2.65 V forces chip reset to protect flash.
// - Brownout reset holds down to about 1 V, then power-on reset takes over.
// - Valid flash checksum and key 0x8765_4321 at 0x1FC disable debug access.
// - Disabled debug access returns only after a full chip erase.
// - A mapping control selects boot ROM, SRAM or external memory vectors at address 0.
// - Up to 50 edge and four level external interrupts may wake from power-down.
// - Sleep exit resumes after 4 cycles on internal, 4096 on main oscillator.
//
// The implementer's own choices: the APB register port and the register offsets.
module reset_brownout_system_control #(
   parameter int                  EDGE_N         = 50,
   parameter int                  LEVEL_N        = 4,
   parameter logic [12:0]         RST_HOLD       = sysctl_pkg::RST_HOLD_CLKS,
   parameter logic [12:0]         WAKE_MAIN      = sysctl_pkg::WAKE_MAIN_CLKS
) (
   // Clock and power-on reset
   input  wire logic               core_clk_i,
   input  wire logic               rst_n_i,
   // Reset sources, brownout warning and release conditions
   input  wire logic               ext_rst_n_i,
   input  wire logic               wdt_rst_i,
   input  wire logic               brownout_rst_i,
   input  wire logic               brownout_warn_i,
   input  wire logic               osc_ok_i,
   input  wire logic               flash_init_done_i,
   // Boot loader flash check and chip erase
   input  wire logic               flash_check_stb_i,
   input  wire logic               flash_sum_ok_i,
   input  wire logic [11:0]        flash_addr_i,
   input  wire logic [31:0]        flash_word_i,
   input  wire logic               chip_erase_done_i,
   // Power-down and external interrupts
   input  wire logic               powerdown_i,
   input  wire logic               irc_src_i,
   input  wire logic [EDGE_N-1:0]  eint_edge_i,
   input  wire logic [LEVEL_N-1:0] eint_level_i,
   // Register bus
   input  wire logic               psel_i,
   input  wire logic               penable_i,
   input  wire logic               pwrite_i,
   input  wire logic [7:0]         paddr_i,
   input  wire logic [31:0]        pwdata_i,
   output logic      [31:0]        prdata_o,
   output logic                    pready_o,
   output logic                    pslverr_o,
   // System outputs
   output logic                    sys_rst_n_o,
   output logic                    brownout_irq_o,
   output logic                    debug_disable_o,
   output logic      [1:0]         vector_map_o,
   output logic                    wake_o,
   output logic                    resume_o,
   output logic                    irq_o
);

   localparam int SYNC_W  = EDGE_N + LEVEL_N + 4;
   localparam int TW      = sysctl_pkg::TIMER_W;
   localparam int IRQ_W_C = sysctl_pkg::IRQ_W;

   // ==========================================================================
   // Reset combining and pin synchronisers
   logic               src_arst_n;
   logic [SYNC_W-1:0]  sync_q;
   logic               ext_ok;
   logic               osc_ok;
   logic               warn_s;
   logic               brst_s;
   logic [EDGE_N-1:0]  edge_s;
   logic [LEVEL_N-1:0] lvl_s;

   // Pin sources assert reset at once, without waiting for a clock edge.
   // Brownout reset and power-on reset overlap as the supply falls.
   assign src_arst_n = rst_n_i & ext_rst_n_i & ~brownout_rst_i;

   sync_2ff #(.W(SYNC_W)) u_sync (
      .clk_i   (core_clk_i),
      .rst_n_i (rst_n_i),
      .d_i     ({eint_level_i, eint_edge_i, brownout_rst_i, brownout_warn_i, osc_ok_i,
                 ext_rst_n_i}),
      .q_o     (sync_q)
   );

   assign ext_ok = sync_q[0];
   assign osc_ok = sync_q[1];
   assign warn_s = sync_q[2];
   assign brst_s = sync_q[3];
   assign edge_s = sync_q[EDGE_N+3:4];
   assign lvl_s  = sync_q[SYNC_W-1:EDGE_N+4];

   // ==========================================================================
   // Reset sequencer
   sysctl_pkg::rst_state_e state;
   sysctl_pkg::rst_state_e next_state;
   logic                   tmr_start;
   logic [TW-1:0]          tmr_len;
   logic                   tmr_done;
   logic                   wake_evt;
   logic                   src_hit;

   assign src_hit = wdt_rst_i | brst_s | ~ext_ok;

   always_comb begin
      next_state = state;
      unique case (state)
         sysctl_pkg::ST_HOLD: begin
            if (ext_ok && osc_ok) begin
               next_state = sysctl_pkg::ST_COUNT;
            end
         end
         sysctl_pkg::ST_COUNT: begin
            if (tmr_done) begin
               next_state = sysctl_pkg::ST_FLASH;
            end
         end
         sysctl_pkg::ST_FLASH: begin
            if (flash_init_done_i) begin
               next_state = sysctl_pkg::ST_RUN;
            end
         end
         sysctl_pkg::ST_RUN: begin
            next_state = sysctl_pkg::ST_RUN;
         end
      endcase
      // Watchdog and synchronised sources restart the whole sequence.
      if (src_hit) begin
         next_state = sysctl_pkg::ST_HOLD;
      end
   end

   always_ff @(posedge core_clk_i or negedge src_arst_n) begin
      if (!src_arst_n) begin
         state <= sysctl_pkg::ST_HOLD;
      end else begin
         state <= next_state;
      end
   end

   // Release only from the flash wait state, on a clock edge.
   always_ff @(posedge core_clk_i or negedge src_arst_n) begin
      if (!src_arst_n) begin
         sys_rst_n_o <= 1'b0;
      end else begin
         sys_rst_n_o <= (next_state == sysctl_pkg::ST_RUN);
      end
   end

   // One timer serves the reset hold count and the sleep exit count.
   assign tmr_start = ((state == sysctl_pkg::ST_HOLD) && ext_ok && osc_ok && !src_hit)
                      || wake_evt;
   assign tmr_len   = (state != sysctl_pkg::ST_RUN) ? RST_HOLD :
                      (irc_src_i ? sysctl_pkg::WAKE_IRC_CLKS : WAKE_MAIN);

   cycle_timer #(.W(TW)) u_timer (
      .clk_i   (core_clk_i),
      .rst_n_i (src_arst_n),
      .start_i (tmr_start),
      .len_i   (tmr_len),
      .busy_o  (),
      .done_o  (tmr_done)
   );

   // ==========================================================================
   // Register bus decode
   logic                   setup;
   logic                   access;
   logic                   wr_acc;
   logic                   rd_stat;
   logic                   hit;
   logic [31:0]            rd_val;
   logic [IRQ_W_C-1:0]     irq_stat;
   logic [IRQ_W_C-1:0]     irq_mask;
   logic [IRQ_W_C-1:0]     irq_ev;
   logic [IRQ_W_C-1:0]     next_irq_stat;
   logic [EDGE_N-1:0]      wake_edge_en;
   logic [LEVEL_N-1:0]     wake_lvl_en;
   logic [63:0]            edge_en_pad;
   logic                   waking;

   function automatic logic is_mapped(input logic [7:0] a);
      return (a == sysctl_pkg::CTRL_OFF)     || (a == sysctl_pkg::STATUS_OFF)   ||
             (a == sysctl_pkg::IRQ_STAT_OFF) || (a == sysctl_pkg::IRQ_MASK_OFF) ||
             (a == sysctl_pkg::WAKE_LO_OFF)  || (a == sysctl_pkg::WAKE_HI_OFF)  ||
             (a == sysctl_pkg::WAKE_LVL_OFF);
   endfunction : is_mapped

   assign setup       = psel_i & ~penable_i;
   assign access      = psel_i & penable_i & pready_o;
   assign wr_acc      = access & pwrite_i;
   assign rd_stat     = access & ~pwrite_i & (paddr_i == sysctl_pkg::IRQ_STAT_OFF);
   assign hit         = is_mapped(paddr_i);
   assign edge_en_pad = 64'(wake_edge_en);

   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (paddr_i)
         sysctl_pkg::CTRL_OFF:     rd_val = 32'(vector_map_o);
         sysctl_pkg::STATUS_OFF: begin
            // Brownout level readable here when its interrupt is not used.
            rd_val[sysctl_pkg::ST_BROWNOUT] = warn_s;
            rd_val[sysctl_pkg::ST_DBG_OFF]  = debug_disable_o;
            rd_val[sysctl_pkg::ST_OSC_OK]   = osc_ok;
            rd_val[sysctl_pkg::ST_WAKING]   = waking;
         end
         sysctl_pkg::IRQ_STAT_OFF: rd_val = 32'(irq_stat);
         sysctl_pkg::IRQ_MASK_OFF: rd_val = 32'(irq_mask);
         sysctl_pkg::WAKE_LO_OFF:  rd_val = edge_en_pad[31:0];
         sysctl_pkg::WAKE_HI_OFF:  rd_val = edge_en_pad[63:32];
         sysctl_pkg::WAKE_LVL_OFF: rd_val = 32'(wake_lvl_en);
         default:                  rd_val = 32'h0000_0000;
      endcase
   end

   // Zero-wait slave: read data is captured in the setup cycle.
   always_ff @(posedge core_clk_i or negedge src_arst_n) begin
      if (!src_arst_n) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else begin
         pready_o  <= setup;
         pslverr_o <= setup & ~hit;
         prdata_o  <= (setup && !pwrite_i) ? rd_val : 32'h0000_0000;
      end
   end

   // ==========================================================================
   // Control registers, cleared again by any internal reset
   always_ff @(posedge core_clk_i or negedge src_arst_n) begin
      if (!src_arst_n) begin
         vector_map_o <= sysctl_pkg::MAP_BOOT;
         irq_mask     <= sysctl_pkg::IRQ_MASK_RST;
         wake_lvl_en  <= '0;
         wake_edge_en <= '0;
      end else if (!sys_rst_n_o) begin
         vector_map_o <= sysctl_pkg::MAP_BOOT;
         irq_mask     <= sysctl_pkg::IRQ_MASK_RST;
         wake_lvl_en  <= '0;
         wake_edge_en <= '0;
      end else if (wr_acc) begin
         // The reserved mapping code is refused and the old mapping kept.
         if (paddr_i == sysctl_pkg::CTRL_OFF && pwdata_i[1:0] != sysctl_pkg::MAP_RESERVED) begin
            vector_map_o <= pwdata_i[1:0];
         end
         if (paddr_i == sysctl_pkg::IRQ_MASK_OFF) begin
            irq_mask <= pwdata_i[IRQ_W_C-1:0];
         end
         if (paddr_i == sysctl_pkg::WAKE_LVL_OFF) begin
            wake_lvl_en <= pwdata_i[LEVEL_N-1:0];
         end
         for (int i = 0; i < EDGE_N; i++) begin
            if (paddr_i == ((i < 32) ? sysctl_pkg::WAKE_LO_OFF : sysctl_pkg::WAKE_HI_OFF)) begin
               wake_edge_en[i] <= pwdata_i[i % 32];
            end
         end
      end
   end

   // ==========================================================================
   // Code security
   logic sec_checked;

   always_ff @(posedge core_clk_i or negedge src_arst_n) begin
      if (!src_arst_n) begin
         debug_disable_o <= 1'b1;
         sec_checked     <= 1'b0;
      end else if (!sys_rst_n_o) begin
         debug_disable_o <= 1'b1;
         sec_checked     <= 1'b0;
      end else if (chip_erase_done_i) begin
         debug_disable_o <= 1'b0;
         sec_checked     <= 1'b1;
      end else if (flash_check_stb_i && !sec_checked
                   && flash_addr_i == sysctl_pkg::SEC_WORD_ADDR) begin
         // Only the first check after reset decides; later ones cannot reopen.
         debug_disable_o <= flash_sum_ok_i && (flash_word_i == sysctl_pkg::SEC_WORD_KEY);
         sec_checked     <= 1'b1;
      end
   end

   // ==========================================================================
   // Brownout warning, wake-up and interrupts
   logic               warn_q;
   logic [EDGE_N-1:0]  edge_q;
   logic               wake_hit;

   // Enabled rising edges and enabled levels wake the core from power-down.
   assign wake_hit = |(edge_s & ~edge_q & wake_edge_en) | |(lvl_s & wake_lvl_en);
   assign wake_evt = (state == sysctl_pkg::ST_RUN) && powerdown_i && !waking && wake_hit;

   assign irq_ev[sysctl_pkg::IRQ_BROWNOUT] = warn_s & ~warn_q;
   assign irq_ev[sysctl_pkg::IRQ_WAKE]     = wake_evt;
   assign irq_ev[sysctl_pkg::IRQ_RESUME]   = waking & tmr_done;

   // Read clears only the bits that were returned; a new event wins.
   assign next_irq_stat = (irq_stat & ~(rd_stat ? prdata_o[IRQ_W_C-1:0] : '0)) | irq_ev;

   always_ff @(posedge core_clk_i or negedge src_arst_n) begin
      if (!src_arst_n) begin
         warn_q <= 1'b0;
         edge_q <= '0;
      end else begin
         warn_q <= warn_s;
         edge_q <= edge_s;
      end
   end

   always_ff @(posedge core_clk_i or negedge src_arst_n) begin
      if (!src_arst_n) begin
         brownout_irq_o <= 1'b0;
         irq_stat       <= '0;
         irq_o          <= 1'b0;
      end else if (!sys_rst_n_o) begin
         brownout_irq_o <= 1'b0;
         irq_stat       <= '0;
         irq_o          <= 1'b0;
      end else begin
         brownout_irq_o <= warn_s;
         irq_stat       <= next_irq_stat;
         irq_o          <= |(next_irq_stat & irq_mask);
      end
   end

   // Resume after the oscillator-dependent count.
   always_ff @(posedge core_clk_i or negedge src_arst_n) begin
      if (!src_arst_n) begin
         waking   <= 1'b0;
         wake_o   <= 1'b0;
         resume_o <= 1'b0;
      end else begin
         waking   <= wake_evt | (waking & ~tmr_done);
         wake_o   <= wake_evt | (waking & ~tmr_done);
         resume_o <= waking & tmr_done;
      end
   end

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!src_arst_n);

   a_wdt_forces_reset: assert property (wdt_rst_i |=> !sys_rst_n_o)
      else $error("watchdog request did not assert internal reset");
   a_release_conditions: assert property ($rose(sys_rst_n_o) |->
      $past(flash_init_done_i) && $past(ext_ok) && $past(osc_ok))
      else $error("reset released before its conditions held");
   a_boot_map_release: assert property ($rose(sys_rst_n_o) |->
      vector_map_o == sysctl_pkg::MAP_BOOT)
      else $error("vectors not mapped to boot block at reset release");
   a_regs_at_reset: assert property (!sys_rst_n_o |=> irq_mask == '0 && irq_stat == '0
      && wake_lvl_en == '0)
      else $error("register not at reset value during reset");
   a_brownout_irq_follow: assert property (sys_rst_n_o && warn_s |=> brownout_irq_o)
      else $error("brownout warning not forwarded");
   a_brownout_sticky: assert property (sys_rst_n_o && warn_s && !warn_q
      |=> irq_stat[sysctl_pkg::IRQ_BROWNOUT])
      else $error("brownout event not recorded");
   a_brownout_reset: assert property (brst_s |=> !sys_rst_n_o ##1 !sys_rst_n_o)
      else $error("brownout reset did not hold internal reset");
   a_debug_reopen: assert property ($fell(debug_disable_o) |->
      $past(chip_erase_done_i) || !$past(sec_checked))
      else $error("debug access reopened without chip erase");
   a_debug_lock_key: assert property (sys_rst_n_o && !chip_erase_done_i && flash_check_stb_i
      && !sec_checked && flash_addr_i == sysctl_pkg::SEC_WORD_ADDR && flash_sum_ok_i
      && flash_word_i == sysctl_pkg::SEC_WORD_KEY |=> debug_disable_o [*3])
      else $error("secured flash did not keep debug disabled");
   a_map_reserved: assert property (vector_map_o != sysctl_pkg::MAP_RESERVED)
      else $error("reserved vector mapping taken");
   a_wake_on_edge: assert property (wake_evt |=> wake_o && $stable(state))
      else $error("wake event did not raise wake request");
   a_irc_resume_time: assert property (wake_evt && irc_src_i |-> ##5 resume_o)
      else $error("internal oscillator resume not after four cycles");

   c_reset_release: cover property ($rose(sys_rst_n_o));
   c_brownout_irq:  cover property (irq_o && irq_stat[sysctl_pkg::IRQ_BROWNOUT]);
   c_debug_locked:  cover property (sys_rst_n_o && sec_checked && debug_disable_o);
   c_irc_resume:    cover property (resume_o && irc_src_i);

endmodule : reset_brownout_system_control

// ### verification/cpu_vic_model.sv
// Behavioural model of the processor core and interrupt controller beside the block.
module cpu_vic_model (
   // Clock and internal reset
   input  wire logic        core_clk_i,
   input  wire logic        sys_rst_n_i,
   // Requests from the block and the controller enable
   input  wire logic        brownout_irq_i,
   input  wire logic        irq_enable_i,
   // Core view
   output logic      [31:0] fetch_addr_o,
   output logic             cpu_irq_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Fetching restarts at address zero and steps one word per cycle.
   always_ff @(posedge core_clk_i or negedge sys_rst_n_i) begin
      if (!sys_rst_n_i) begin
         fetch_addr_o <= 32'h0000_0000;
      end else begin
         fetch_addr_o <= fetch_addr_o + 32'h0000_0004;
      end
   end

   assign cpu_irq_o = brownout_irq_i & irq_enable_i;
endmodule : cpu_vic_model

// ### verification/reset_brownout_system_control_bench.sv
// Self-checking bench for the reset and system-control block.
module reset_brownout_system_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [12:0] HOLD  = 13'h0004;
   localparam logic [12:0] WMAIN = 13'h0008;
   logic        core_clk_i, rst_n_i, ext_rst_n_i, wdt_rst_i, brownout_rst_i, brownout_warn_i;
   logic        osc_ok_i, flash_init_done_i, flash_check_stb_i, flash_sum_ok_i;
   logic        chip_erase_done_i, powerdown_i, irc_src_i, psel_i, penable_i, pwrite_i;
   logic        pready_o, pslverr_o, sys_rst_n_o, brownout_irq_o, debug_disable_o;
   logic        wake_o, resume_o, irq_o, irq_enable, cpu_irq, perr;
   logic [1:0]  vector_map_o;
   logic [7:0]  paddr_i;
   logic [11:0] flash_addr_i;
   logic [31:0] flash_word_i, pwdata_i, prdata_o, fetch_addr, rd;
   logic [49:0] eint_edge_i;
   logic [3:0]  eint_level_i;
   int          miscompares, comparisons, n;

   reset_brownout_system_control #(.EDGE_N(50), .LEVEL_N(4), .RST_HOLD(HOLD), .WAKE_MAIN(WMAIN))
   u_dut (.core_clk_i, .rst_n_i, .ext_rst_n_i, .wdt_rst_i, .brownout_rst_i, .brownout_warn_i,
      .osc_ok_i, .flash_init_done_i, .flash_check_stb_i, .flash_sum_ok_i, .flash_addr_i,
      .flash_word_i, .chip_erase_done_i, .powerdown_i, .irc_src_i, .eint_edge_i, .eint_level_i,
      .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .sys_rst_n_o, .brownout_irq_o, .debug_disable_o, .vector_map_o, .wake_o, .resume_o, .irq_o);
   cpu_vic_model u_cpu (.core_clk_i, .sys_rst_n_i(sys_rst_n_o), .brownout_irq_i(brownout_irq_o),
      .irq_enable_i(irq_enable), .fetch_addr_o(fetch_addr), .cpu_irq_o(cpu_irq));

   // ==========================================================================
   // Shared tasks
   task complete_run;
      if (miscompares == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge core_clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      perr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task rchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
      chk(perr, experr);
   endtask : rchk

   task wait_rel;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (sys_rst_n_o !== 1'b1 && n < 200);
      chk(sys_rst_n_o, 1);
      chk(fetch_addr, 0);
      chk(vector_map_o, 0);
      chk(debug_disable_o, 1);
   endtask : wait_rel

   task flash_chk(input logic ok, input logic [31:0] w);
      @(posedge core_clk_i);
      flash_check_stb_i <= 1'b1;
      flash_sum_ok_i <= ok;
      flash_addr_i <= sysctl_pkg::SEC_WORD_ADDR;
      flash_word_i <= w;
      @(posedge core_clk_i) flash_check_stb_i <= 1'b0;
      @(posedge core_clk_i);
   endtask : flash_chk

   task wake_run(input logic irc, input int gap);
      @(posedge core_clk_i);
      powerdown_i <= 1'b1;
      irc_src_i <= irc;
      eint_level_i <= irc ? 4'h1 : 4'h0;
      eint_edge_i <= irc ? 50'h0 : 50'h1 << 40;
      n = 0;
      while (wake_o !== 1'b1 && n < 20) begin
         @(posedge core_clk_i);
         n++;
      end
      chk(wake_o, 1);
      powerdown_i <= 1'b0;
      eint_level_i <= 4'h0;
      eint_edge_i <= 50'h0;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (resume_o !== 1'b1 && n < 5000);
      chk(n, gap);
      rchk(sysctl_pkg::IRQ_STAT_OFF, 32'h0000_0006, 0);
   endtask : wake_run

   // ==========================================================================
   // Clock, watchdog and test sequence
   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   initial begin
      repeat (5000) @(posedge core_clk_i);
      miscompares++;
      complete_run();
   end

   initial begin
      {rst_n_i, wdt_rst_i, brownout_rst_i, brownout_warn_i, osc_ok_i, flash_init_done_i,
       flash_check_stb_i, flash_sum_ok_i, chip_erase_done_i, powerdown_i, psel_i, penable_i,
       pwrite_i, irq_enable, paddr_i, flash_addr_i, flash_word_i, pwdata_i, eint_edge_i,
       eint_level_i, miscompares, comparisons} = '0;
      ext_rst_n_i = 1'b1;
      irc_src_i = 1'b1;
      repeat (10) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      osc_ok_i <= 1'b1;
      repeat (30) @(posedge core_clk_i);
      chk(sys_rst_n_o, 0);
      flash_init_done_i <= 1'b1;
      wait_rel();
      rchk(sysctl_pkg::CTRL_OFF, 0, 0);
      rchk(sysctl_pkg::IRQ_MASK_OFF, 0, 0);
      rchk(8'h1C, 0, 1);
      flash_chk(1'b1, 32'h1234_5678);
      chk(debug_disable_o, 0);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, sysctl_pkg::CTRL_OFF, i);
         rchk(sysctl_pkg::CTRL_OFF, (i == 3) ? 2 : i, 0);
         chk(vector_map_o, (i == 3) ? 2 : i);
      end
      apb(1'b1, sysctl_pkg::IRQ_MASK_OFF, 32'h0000_0001);
      @(posedge core_clk_i) brownout_warn_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      chk(brownout_irq_o, 1);
      chk(cpu_irq, 0);
      chk(irq_o, 1);
      irq_enable <= 1'b1;
      @(posedge core_clk_i);
      chk(cpu_irq, 1);
      rchk(sysctl_pkg::STATUS_OFF, 32'h0000_0005, 0);
      rchk(sysctl_pkg::IRQ_STAT_OFF, 32'h0000_0001, 0);
      rchk(sysctl_pkg::IRQ_STAT_OFF, 0, 0);
      chk(irq_o, 0);
      brownout_warn_i <= 1'b0;
      @(posedge core_clk_i) brownout_rst_i <= 1'b1;
      #1;
      chk(sys_rst_n_o, 0);
      repeat (20) @(posedge core_clk_i);
      rst_n_i <= 1'b0;
      @(posedge core_clk_i) brownout_rst_i <= 1'b0;
      repeat (20) @(posedge core_clk_i);
      chk(sys_rst_n_o, 0);
      rst_n_i <= 1'b1;
      wait_rel();
      flash_chk(1'b1, sysctl_pkg::SEC_WORD_KEY);
      chk(debug_disable_o, 1);
      flash_chk(1'b1, 32'h1234_5678);
      chk(debug_disable_o, 1);
      @(posedge core_clk_i) chip_erase_done_i <= 1'b1;
      @(posedge core_clk_i) chip_erase_done_i <= 1'b0;
      @(posedge core_clk_i);
      chk(debug_disable_o, 0);
      @(posedge core_clk_i) wdt_rst_i <= 1'b1;
      @(posedge core_clk_i) wdt_rst_i <= 1'b0;
      @(posedge core_clk_i);
      chk(sys_rst_n_o, 0);
      wait_rel();
      @(posedge core_clk_i) brownout_rst_i <= 1'b1;
      @(posedge core_clk_i) brownout_rst_i <= 1'b0;
      chk(sys_rst_n_o, 0);
      wait_rel();
      @(posedge core_clk_i) ext_rst_n_i <= 1'b0;
      #1;
      chk(sys_rst_n_o, 0);
      @(posedge core_clk_i) ext_rst_n_i <= 1'b1;
      wait_rel();
      apb(1'b1, sysctl_pkg::WAKE_LVL_OFF, 32'h0000_0001);
      apb(1'b1, sysctl_pkg::WAKE_HI_OFF, 32'h0000_0100);
      wake_run(1'b1, 4);
      wake_run(1'b0, WMAIN);
      complete_run();
   end
endmodule : reset_brownout_system_control_bench
